// >>> design/lpm_pkg.sv
// lpm_pkg: constants and types of the low-power mode controller
// assumes APB slave with 32-bit data, one word per register
package lpm_pkg;
   // register indices; the byte address is four times the index
   localparam logic [15:0] REG_IDX_PMC  = 16'hFFF0;
   localparam logic [15:0] REG_IDX_DTC  = 16'hFFF1;
   localparam logic [15:0] REG_IDX_CTL  = 16'hFFF2;
   localparam logic [15:0] REG_IDX_STAT = 16'hFFF3;
   localparam logic [17:0] ADDR_PMC  = {REG_IDX_PMC, 2'b00};
   localparam logic [17:0] ADDR_DTC  = {REG_IDX_DTC, 2'b00};
   localparam logic [17:0] ADDR_CTL  = {REG_IDX_CTL, 2'b00};
   localparam logic [17:0] ADDR_STAT = {REG_IDX_STAT, 2'b00};
   // field positions
   localparam int PMC_STBY_BIT = 7;
   localparam int PMC_STS_LSB  = 4;
   localparam int PMC_LOWSPD_BIT = 3;
   localparam int PMC_RSV_BIT  = 2;
   localparam int DTC_DTEN_BIT = 3;
   localparam int CTL_TCS_BIT  = 0;
   // reset values
   localparam logic [7:0] PMC_RESET = 8'h00;
   localparam logic [7:0] DTC_RESET = 8'hF4;
   localparam logic [7:0] DTC_FIXED = 8'hF4;
   localparam logic [7:0] CTL_RESET = 8'h00;
   // oscillator and system clock gate on, everything else off
   localparam logic [7:0] PWR_RESET = 8'hC0;
   // settle wait, in states of the system clock
   localparam logic [17:0] WAIT_0 = 18'h02000;
   localparam logic [17:0] WAIT_1 = 18'h04000;
   localparam logic [17:0] WAIT_2 = 18'h08000;
   localparam logic [17:0] WAIT_3 = 18'h10000;
   localparam logic [17:0] WAIT_4 = 18'h20000;
   // recommended least wait with a ceramic resonator
   localparam int SETTLE_MIN_MS     = 10;
   localparam int CLK_HZ            = 40000000;
   localparam int SETTLE_MIN_CYCLES = (CLK_HZ / 1000) * SETTLE_MIN_MS;

   typedef enum logic [2:0] {
      LPM_ACTIVE, LPM_SLEEP, LPM_STANDBY, LPM_WATCH, LPM_SETTLE, LPM_SUBACTIVE
   } lpm_mode_t;

   // wake request lines from the cpu side
   typedef struct packed {
      logic tb_irq;
      logic ext0_irq;
      logic ext1_irq;
      logic tb_en;
      logic ext0_en;
      logic ext1_en;
      logic dt_en;
   } lpm_wake_t;

   // power controls to clocks and peripherals
   typedef struct packed {
      logic main_osc_on;
      logic sysclk_gate;
      logic cpu_on_subclk;
      logic cpu_halt;
      logic periph_stop;
      logic periph_rst;
      logic io_hiz;
      logic tb_on_subclk;
   } lpm_pwr_t;
endpackage

// >>> design/lpm_ctrl.sv
// lpm_ctrl: power-mode sequencer with three control registers and a status register on APB
// assumes the cpu pulses sleep_i per sleep instruction and holds its mask on cpu_imask_i
//
// Overview of operation
// R1: active sleep with standby_select=1 and timer_clock_source_bit=1 enters watch
// R2: subactive sleep with direct_transfer_enable=0 enters watch
// R3: watch stops main oscillator and peripherals except time base, resets outputs
// R4: watch left only by time-base irq, external_interrupt_zero, or reset_pin
// R5: wake with low_speed_select=0 starts oscillator, waits, returns active, takes irq
// R6: wake with low_speed_select=1 enters subactive instead
// R7: wake ignored when cpu mask set or source disabled
// R8: in watch the prescaled subclock drives the timer time base
// R9: subactive runs cpu on subclock, peripherals halted, i/o high impedance
// R10: subactive sleep with direct_transfer_enable=1 and low_speed_select=0 raises direct irq
// R11: direct transfer passes through watch while the oscillator settles
// R12: direct transfer suppressed by cpu mask or disabled direct irq
// R13: no direct transfer while low_speed_select is 1
// R14: software should program at least 10 ms wait for ceramic resonators; the longest wait here, 131072 states, is about 3.3 ms at CLK_HZ
// R15: standby_select=0 makes sleep enter sleep mode, 1 standby or watch
// R16: standby_select writable only in active mode and stays 1 after wake
// R17: three-bit field picks 8192 to 131072 state settle wait
// R18: first register bit 2 read/write, bits 1 and 0 read zero
// R19: direct_transfer_enable writable only in subactive mode
// R20: second register bits 7-4 and 2 read 1, bits 1-0 read 0
// R21: reset_pin low restarts oscillator and leaves low-power mode
// R22: any reset returns to active with initial register values
//
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
module lpm_ctrl (
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              psel_i,
   input  wire logic              penable_i,
   input  wire logic              pwrite_i,
   input  wire logic [31:0]       paddr_i,
   input  wire logic [31:0]       pwdata_i,
   input  wire logic [3:0]        pstrb_i,
   output logic      [31:0]       prdata_o,
   output logic                   pready_o,
   output logic                   pslverr_o,
   input  wire logic              sleep_i,
   input  wire logic              cpu_imask_i,
   input  wire lpm_pkg::lpm_wake_t wake_i,
   output lpm_pkg::lpm_pwr_t      pwr_o,
   output logic                   irq_take_o,
   output logic                   direct_irq_o,
   output logic [2:0]             mode_o
);
   import lpm_pkg::*;

   // ==========================================================
   // registers and decode
   // ==========================================================
   logic            stby_q;
   logic            lowspd_q;
   logic            rsv_q;
   logic            dtr_on_q;
   logic            tcs_q;
   logic [2:0]      sts_q;
   lpm_mode_t       mode_q;
   lpm_mode_t       mode_d;
   logic [17:0]     cnt_q;
   logic [17:0]     cnt_d;
   lpm_pwr_t        pwr_d;
   logic            irq_take_d;
   logic            direct_irq_d;

   wire  [17:0] adr       = paddr_i[17:0];
   wire         wr_stb    = psel_i & penable_i & pwrite_i & pstrb_i[0];
   wire         rd_acc    = psel_i & ~penable_i & ~pwrite_i;
   wire         hit_pmc   = (adr == ADDR_PMC);
   wire         hit_dtc   = (adr == ADDR_DTC);
   wire         hit_ctl   = (adr == ADDR_CTL);
   wire         hit_stat  = (adr == ADDR_STAT);
   wire         hit_any   = hit_pmc | hit_dtc | hit_ctl | hit_stat;
   wire         in_active = (mode_q == LPM_ACTIVE);
   wire         in_sub    = (mode_q == LPM_SUBACTIVE);
   wire         wr_pmc    = wr_stb & hit_pmc;
   wire         wr_stby   = wr_pmc & in_active;         // R16
   wire         wr_dtc    = wr_stb & hit_dtc & in_sub;  // R19
   wire         wr_ctl    = wr_stb & hit_ctl;

   wire  [7:0]  pmc_rd = {stby_q, sts_q, lowspd_q, rsv_q, 2'b00}; // R18
   wire  [7:0]  dtc_rd = DTC_FIXED | {4'h0, dtr_on_q, 3'b000};    // R20

   function automatic logic [17:0] settle_len(input logic [2:0] sel);
      case (sel) // R17
         3'b000:  settle_len = WAIT_0;
         3'b001:  settle_len = WAIT_1;
         3'b010:  settle_len = WAIT_2;
         3'b011:  settle_len = WAIT_3;
         default: settle_len = WAIT_4;
      endcase
   endfunction

   // ==========================================================
   // wake qualification
   // ==========================================================
   wire tb_wake   = wake_i.tb_irq & wake_i.tb_en & ~cpu_imask_i;     // R7
   wire ext0_wake = wake_i.ext0_irq & wake_i.ext0_en & ~cpu_imask_i; // R7
   wire ext1_wake = wake_i.ext1_irq & wake_i.ext1_en & ~cpu_imask_i;
   wire watch_wake = tb_wake | ext0_wake;                            // R4
   wire sleep_wake = tb_wake | ext0_wake | ext1_wake;
   wire stby_wake  = ext0_wake | ext1_wake;
   wire dt_ok      = dtr_on_q & ~lowspd_q & wake_i.dt_en & ~cpu_imask_i; // R12 R13

   // ==========================================================
   // mode sequencer
   // ==========================================================
   always_comb begin
      mode_d   = mode_q;
      cnt_d    = cnt_q;
      case (mode_q)
         LPM_ACTIVE: begin
            if (sleep_i) begin
               if (!stby_q) begin
                  mode_d = LPM_SLEEP; // R15
               end else if (tcs_q) begin
                  mode_d = LPM_WATCH; // R1
               end else begin
                  mode_d = LPM_STANDBY; // R15
               end
            end
         end
         LPM_SLEEP: begin
            if (sleep_wake) begin
               mode_d = LPM_ACTIVE;
            end
         end
         LPM_STANDBY: begin
            if (stby_wake) begin
               mode_d = LPM_SETTLE;
               cnt_d  = settle_len(sts_q);
            end
         end
         LPM_WATCH: begin
            if (watch_wake) begin
               if (lowspd_q) begin
                  mode_d = LPM_SUBACTIVE; // R6
               end else begin
                  mode_d = LPM_SETTLE; // R5
                  cnt_d  = settle_len(sts_q);
               end
            end
         end
         LPM_SETTLE: begin
            // oscillator running while still held in watch-like state
            if (cnt_q <= 18'h00001) begin
               mode_d = LPM_ACTIVE; // R5 R11
            end else begin
               cnt_d = cnt_q - 18'h00001;
            end
         end
         LPM_SUBACTIVE: begin
            if (sleep_i) begin
               if (dt_ok) begin
                  mode_d = LPM_SETTLE; // R10 R11
                  cnt_d  = settle_len(sts_q);
               end else begin
                  mode_d = LPM_WATCH; // R2
               end
            end
         end
         default: begin
            mode_d = LPM_ACTIVE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         mode_q   <= LPM_ACTIVE; // R21 R22
         cnt_q    <= '0;
      end else begin
         mode_q   <= mode_d;
         cnt_q    <= cnt_d;
      end
   end

   // ==========================================================
   // control registers
   // ==========================================================
   // standby select moves only while the cpu runs in active mode
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         stby_q <= PMC_RESET[PMC_STBY_BIT]; // R22
      end else if (wr_stby) begin
         stby_q <= pwdata_i[PMC_STBY_BIT]; // R16
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sts_q    <= PMC_RESET[PMC_STS_LSB+:3]; // R22
         lowspd_q <= PMC_RESET[PMC_LOWSPD_BIT];
         rsv_q    <= PMC_RESET[PMC_RSV_BIT];
      end else if (wr_pmc) begin
         sts_q    <= pwdata_i[PMC_STS_LSB+:3]; // R17
         lowspd_q <= pwdata_i[PMC_LOWSPD_BIT];
         rsv_q    <= pwdata_i[PMC_RSV_BIT]; // R18
      end
   end

   // direct transfer enable moves only in subactive mode
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         dtr_on_q <= DTC_RESET[DTC_DTEN_BIT]; // R22
      end else if (wr_dtc) begin
         dtr_on_q <= pwdata_i[DTC_DTEN_BIT]; // R19
      end
   end

   // timer clock source select, steers sleep into watch or standby
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         tcs_q <= CTL_RESET[CTL_TCS_BIT]; // R22
      end else if (wr_ctl) begin
         tcs_q <= pwdata_i[CTL_TCS_BIT]; // R1
      end
   end

   // ==========================================================
   // apb answer
   // ==========================================================
   wire [7:0] rd_mux = hit_pmc  ? pmc_rd :
                       hit_dtc  ? dtc_rd :
                       hit_ctl  ? {7'h00, tcs_q} :
                       hit_stat ? {5'h00, mode_q} : 8'h00;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         prdata_o  <= 32'h00000000;
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         pready_o  <= psel_i & ~penable_i;
         pslverr_o <= psel_i & ~penable_i & ~hit_any;
         if (rd_acc) begin
            prdata_o <= {24'h000000, rd_mux};
         end
      end
   end

   // ==========================================================
   // power outputs
   // ==========================================================
   // one row per mode, decoded from the next mode so outputs track mode_o
   always_comb begin
      pwr_d = '0;
      case (mode_d)
         LPM_ACTIVE: begin
            pwr_d.main_osc_on   = 1'b1;
            pwr_d.sysclk_gate   = 1'b1;
         end
         LPM_SLEEP: begin
            pwr_d.main_osc_on   = 1'b1;
            pwr_d.sysclk_gate   = 1'b1;
            pwr_d.cpu_halt      = 1'b1;
         end
         LPM_STANDBY: begin
            pwr_d.cpu_halt      = 1'b1;
            pwr_d.periph_stop   = 1'b1;
            pwr_d.periph_rst    = 1'b1;
            pwr_d.io_hiz        = 1'b1;
         end
         LPM_WATCH: begin
            // main oscillator stays off here
            pwr_d.cpu_halt      = 1'b1; // R3
            pwr_d.periph_stop   = 1'b1; // R3
            pwr_d.periph_rst    = 1'b1; // R3
            pwr_d.tb_on_subclk  = 1'b1; // R8
         end
         LPM_SETTLE: begin
            // still watch for the core, oscillator already running
            pwr_d.main_osc_on   = 1'b1; // R5 R10
            pwr_d.cpu_halt      = 1'b1; // R11
            pwr_d.periph_stop   = 1'b1;
            pwr_d.periph_rst    = 1'b1;
            pwr_d.tb_on_subclk  = 1'b1;
         end
         LPM_SUBACTIVE: begin
            pwr_d.cpu_on_subclk = 1'b1; // R9
            pwr_d.periph_stop   = 1'b1; // R9
            pwr_d.periph_rst    = 1'b1; // R9
            pwr_d.io_hiz        = 1'b1; // R9
            pwr_d.tb_on_subclk  = 1'b1; // R8
         end
         default: begin
            pwr_d.main_osc_on   = 1'b1;
            pwr_d.sysclk_gate   = 1'b1;
         end
      endcase
   end

   wire go_act = (mode_d == LPM_ACTIVE) & ~in_active & (mode_q != LPM_SLEEP);

   assign irq_take_d   = go_act | ((mode_q == LPM_SLEEP) & sleep_wake); // R5
   assign direct_irq_d = in_sub & sleep_i & dt_ok;                     // R10

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pwr_o        <= PWR_RESET; // R21
         irq_take_o   <= 1'b0;
         direct_irq_o <= 1'b0;
         mode_o       <= 3'(LPM_ACTIVE);
      end else begin
         pwr_o        <= pwr_d;
         irq_take_o   <= irq_take_d;
         direct_irq_o <= direct_irq_d;
         mode_o       <= 3'(mode_d);
      end
   end
endmodule

// >>> bench/lpm_ctrl_properties.sv
// lpm_ctrl_chk: port assertions for lpm_ctrl
// assumes it is bound into lpm_ctrl, one clock
`timescale 1ns/10ps
module lpm_ctrl_chk
   import lpm_pkg::*;
(
   input wire logic               clk_i,
   input wire logic               rst_n_i,
   input wire logic               psel_i,
   input wire logic               penable_i,
   input wire logic               pready_o,
   input wire logic               cpu_imask_i,
   input wire logic               sleep_i,
   input wire lpm_pkg::lpm_wake_t wake_i,
   input wire lpm_pkg::lpm_pwr_t  pwr_o,
   input wire logic               irq_take_o,
   input wire logic               direct_irq_o,
   input wire logic [2:0]         mode_o
);
   logic [17:0] stl_q;
   wire         wake_ok = (wake_i.tb_irq & wake_i.tb_en | wake_i.ext0_irq & wake_i.ext0_en) & ~cpu_imask_i;
   // cycles spent in settle
   always_ff @(posedge clk_i) stl_q <= (mode_o == 3'd4) ? stl_q + 18'h00001 : 18'h00000;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   AST_READY: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o)
      else $error("apb ready");
   AST_WATCH_PWR: assert property (mode_o == 3'd3 |-> !pwr_o.main_osc_on && pwr_o.periph_stop && pwr_o.tb_on_subclk)
      else $error("watch power");
   AST_WATCH_HOLD: assert property (mode_o == 3'd3 && !wake_ok |=> mode_o == 3'd3)
      else $error("watch left");
   AST_SUB_SLEEP: assert property (mode_o == 3'd5 && sleep_i |=> mode_o != 3'd0)
      else $error("direct active");
   AST_TAKE: assert property (irq_take_o |-> mode_o == 3'd0)
      else $error("take not active");
   AST_SETTLE_OSC: assert property (mode_o == 3'd4 |-> pwr_o.main_osc_on)
      else $error("settle osc");
   AST_SETTLE_LEN: assert property ($fell(mode_o == 3'd4) |-> stl_q > 18'h01FFC)
      else $error("settle short");
   AST_DIRECT: assert property (direct_irq_o |-> $past(sleep_i && !cpu_imask_i && wake_i.dt_en))
      else $error("direct masked");
   AST_SUB_PWR: assert property (mode_o == 3'd5 |-> pwr_o.cpu_on_subclk && pwr_o.io_hiz && pwr_o.periph_stop)
      else $error("sub power");
   AST_RESET: assert property (disable iff (1'b0) !rst_n_i |=> mode_o == 3'd0 && pwr_o.main_osc_on)
      else $error("reset mode");
   COV_WATCH: cover property (mode_o == 3'd3 ##1 mode_o == 3'd4);
   COV_SUB: cover property (mode_o == 3'd5);
   COV_DIRECT: cover property (direct_irq_o);
   COV_STANDBY: cover property (mode_o == 3'd2 ##1 mode_o == 3'd4);
endmodule
bind lpm_ctrl lpm_ctrl_chk i_lpm_ctrl_chk (.clk_i, .rst_n_i, .psel_i, .penable_i, .pready_o, .cpu_imask_i,
   .sleep_i, .wake_i, .pwr_o, .irq_take_o, .direct_irq_o, .mode_o);

// >>> bench/lpm_cpu_model.sv
// lpm_cpu_model: cpu side, sleep pulses, mask and wake lines
// assumes the clock of lpm_ctrl
`timescale 1ns/10ps
module lpm_cpu_model
   import lpm_pkg::*;
(
   input  wire logic          clk_i,
   output logic               sleep_o,
   output logic               imask_o,
   output lpm_pkg::lpm_wake_t wake_o
);
   initial begin
      sleep_o = 1'b0;
      imask_o = 1'b0;
      wake_o  = 7'h0F;
   end
   // one sleep instruction
   task automatic do_sleep();
      @(posedge clk_i);
      sleep_o <= 1'b1;
      @(posedge clk_i);
      sleep_o <= 1'b0;
   endtask
   task automatic irq(input logic [6:0] w, input logic m);
      @(posedge clk_i);
      wake_o  <= w;
      imask_o <= m;
   endtask
endmodule

// >>> bench/lpm_ctrl_bench.sv
// lpm_ctrl_bench: register and mode sequence tests
// assumes lpm_cpu_model on the cpu side
`timescale 1ns/10ps
module lpm_ctrl_bench;
   import lpm_pkg::*;
   localparam logic [6:0] W_IDLE = 7'h0F;
   localparam logic [6:0] W_TB   = 7'h4F;
   localparam logic [6:0] W_E0   = 7'h2F;
   localparam logic [6:0] W_E1   = 7'h1F;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] paddr = 32'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, err, sleep, imask, take, direct;
   logic [2:0]  mode;
   lpm_wake_t   wake;
   lpm_pwr_t    pwr;
   int          failures = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          n_take = 0;
   int          n_dir = 0;
   int          n, t0;
   always #12.5 clk_i = ~clk_i;
   lpm_ctrl i_lpm_ctrl (.clk_i, .rst_n_i, .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .sleep_i(sleep), .cpu_imask_i(imask), .wake_i(wake), .pwr_o(pwr),
      .irq_take_o(take), .direct_irq_o(direct), .mode_o(mode));
   lpm_cpu_model i_lpm_cpu_model (.clk_i, .sleep_o(sleep), .imask_o(imask), .wake_o(wake));
   always @(posedge clk_i) begin
      cyc++;
      if (take === 1'b1) n_take++;
      if (direct === 1'b1) n_dir++;
      if (cyc == 60000) begin
         failures++;
         results();
      end
   end
   task automatic results();
      if (failures == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d);
      @(posedge clk_i);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= {14'h0000, a};
      pwdata <= {24'h000000, d};
      @(posedge clk_i);
      penable <= 1'b1;
      @(posedge clk_i);
      while (pready !== 1'b1) @(posedge clk_i);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic go(input logic [2:0] m, input int lim);
      n = 0;
      while (mode !== m && n < lim) begin
         @(posedge clk_i);
         n++;
      end
      chk("mode", {29'h0, mode}, {29'h0, m});
   endtask
   task automatic to_sub();
      apb(1'b1, ADDR_PMC, 8'h88);
      i_lpm_cpu_model.do_sleep();
      go(3'd3, 20);
      i_lpm_cpu_model.irq(W_E0, 1'b0);
      go(3'd5, 20);
      i_lpm_cpu_model.irq(W_IDLE, 1'b0);
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      rst_n_i <= 1'b1;
      apb(1'b0, ADDR_PMC, 8'h00);
      chk("pmc", rd, 32'h00);
      apb(1'b0, 18'h00100, 8'h00);
      chk("slverr", {31'h0, err}, 32'h1);
      apb(1'b1, ADDR_PMC, 8'hFF);
      apb(1'b0, ADDR_PMC, 8'h00);
      chk("pmc", rd, 32'hFC);
      apb(1'b1, ADDR_DTC, 8'hFF);
      apb(1'b0, ADDR_DTC, 8'h00);
      chk("dtc", rd, 32'hF4);
      apb(1'b1, ADDR_PMC, 8'h00);
      i_lpm_cpu_model.do_sleep();
      go(3'd1, 20);
      i_lpm_cpu_model.irq(W_TB, 1'b0);
      go(3'd0, 20);
      i_lpm_cpu_model.irq(W_IDLE, 1'b0);
      apb(1'b1, ADDR_CTL, 8'h01);
      apb(1'b1, ADDR_PMC, 8'h80);
      i_lpm_cpu_model.do_sleep();
      go(3'd3, 20);
      chk("pwr", {24'h0, pwr & 8'h8D}, 32'h0D);
      apb(1'b1, ADDR_PMC, 8'h00);
      i_lpm_cpu_model.irq(W_TB, 1'b1);
      repeat (5) @(posedge clk_i);
      i_lpm_cpu_model.irq(W_E1, 1'b0);
      repeat (5) @(posedge clk_i);
      i_lpm_cpu_model.irq(7'h47, 1'b0);
      repeat (5) @(posedge clk_i);
      chk("mode", {29'h0, mode}, 32'h3);
      t0 = n_take;
      i_lpm_cpu_model.irq(W_E0, 1'b0);
      go(3'd4, 20);
      i_lpm_cpu_model.irq(W_IDLE, 1'b0);
      go(3'd0, 9000);
      chk("settle", n > 8185 && n < 8195, 1);
      apb(1'b0, ADDR_PMC, 8'h00);
      chk("pmc", rd, 32'h80);
      chk("take", n_take - t0, 1);
      apb(1'b1, ADDR_CTL, 8'h00);
      i_lpm_cpu_model.do_sleep();
      go(3'd2, 20);
      chk("pwr", {24'h0, pwr & 8'h8A}, 32'h0A);
      i_lpm_cpu_model.irq(W_E1, 1'b0);
      go(3'd4, 20);
      i_lpm_cpu_model.irq(W_IDLE, 1'b0);
      go(3'd0, 9000);
      chk("settle", n > 8185 && n < 8195, 1);
      apb(1'b1, ADDR_CTL, 8'h01);
      to_sub();
      chk("pwr", {24'h0, pwr & 8'h2A}, 32'h2A);
      apb(1'b1, ADDR_PMC, 8'h80);
      i_lpm_cpu_model.do_sleep();
      go(3'd3, 20);
      i_lpm_cpu_model.irq(W_E0, 1'b0);
      go(3'd4, 20);
      i_lpm_cpu_model.irq(W_IDLE, 1'b0);
      go(3'd0, 9000);
      to_sub();
      apb(1'b1, ADDR_DTC, 8'h08);
      t0 = n_dir;
      i_lpm_cpu_model.do_sleep();
      go(3'd3, 20);
      chk("dir", n_dir - t0, 0);
      i_lpm_cpu_model.irq(W_E0, 1'b0);
      go(3'd5, 20);
      i_lpm_cpu_model.irq(W_IDLE, 1'b0);
      apb(1'b1, ADDR_PMC, 8'h80);
      i_lpm_cpu_model.do_sleep();
      go(3'd4, 20);
      go(3'd0, 9000);
      chk("dir", n_dir - t0, 1);
      to_sub();
      apb(1'b1, ADDR_PMC, 8'h80);
      i_lpm_cpu_model.irq(7'h0E, 1'b0);
      i_lpm_cpu_model.do_sleep();
      repeat (20) @(posedge clk_i);
      chk("dir", n_dir - t0, 1);
      rst_n_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b1;
      go(3'd0, 5);
      chk("pwr", {24'h0, pwr}, 32'hC0);
      apb(1'b0, ADDR_PMC, 8'h00);
      chk("pmc", rd, 32'h00);
      results();
   end
endmodule
